// file: core/aps_consts.svh
// constants for the converter power and calibration sequencer
// assumes a 100 mhz system clock and a master clock of a few mhz
`ifndef APS_CONSTS_SVH
`define APS_CONSTS_SVH

// system clock rate, khz
`define APS_REF_KHZ 100000
// master clock rate the printed figures refer to, khz
`define APS_MCLK_KHZ 6000
// master clock rate of the power-on autocalibration figure, khz
`define APS_AUTO_MCLK_KHZ 4000

// durations as printed, in microseconds or nanoseconds
`define APS_POR_TOTAL_US 35000
`define APS_CAL_FULL_US 41700
`define APS_CAL_GO_US 9260
`define APS_CAL_ONE_US 4630
`define APS_AUTO_CAL_US 32000
`define APS_CONV_NS 3250
`define APS_WAKE_NS 5000

// cycle counts; least times round up, all but wake-up counted on master clock edges
`define APS_POR_CYC ((`APS_POR_TOTAL_US * `APS_MCLK_KHZ + 999) / 1000)
`define APS_CAL_FULL_CYC ((`APS_CAL_FULL_US * `APS_MCLK_KHZ + 999) / 1000)
`define APS_CAL_GO_CYC ((`APS_CAL_GO_US * `APS_MCLK_KHZ + 999) / 1000)
`define APS_CAL_ONE_CYC ((`APS_CAL_ONE_US * `APS_MCLK_KHZ + 999) / 1000)
`define APS_AUTO_CAL_CYC ((`APS_AUTO_CAL_US * `APS_AUTO_MCLK_KHZ + 999) / 1000)
`define APS_CONV_CYC ((`APS_CONV_NS * `APS_MCLK_KHZ + 999999) / 1000000)
// wake-up is timed on the system clock, it is an analog settling time
`define APS_WAKE_CYC ((`APS_WAKE_NS * `APS_REF_KHZ + 999999) / 1000000)

// width of the shared duration counter
`define APS_CNT_W 18

// calibration type codes in the control word
`define APS_CAL_FULL 2'h0
`define APS_CAL_GO 2'h1
`define APS_CAL_OFF 2'h2
`define APS_CAL_GAIN 2'h3

`endif

// file: core/aps_pkg.sv
// types for the converter power and calibration sequencer
// assumes aps_consts.svh is found on the include path
`include "aps_consts.svh"

package aps_pkg;

    // sequencer states
    typedef enum logic [2:0] {
        ST_POR_WAIT,
        ST_POR_CAL,
        ST_IDLE,
        ST_SLEEP,
        ST_WAKE,
        ST_CONV,
        ST_CAL
    } aps_state_t;

    // effective power policy after bits and pin are combined
    typedef enum logic [1:0] {
        POL_PD_BETWEEN_FULL,
        POL_POWER_UP,
        POL_PD_FULL,
        POL_PD_BETWEEN_PART
    } aps_policy_t;

    // control word written by the host
    typedef struct packed {
        logic power_policy_bit_hi;
        logic power_policy_bit_lo;
        logic trim_start_bit;
        logic [1:0] cal_type;
    } aps_ctrl_t;

    // whole module state
    typedef struct packed {
        aps_state_t st;
        logic [`APS_CNT_W-1:0] cnt;
        aps_ctrl_t ctrl;
        logic first_cal;
        logic pend_conv;
        logic pend_cal;
        logic busy;
        logic awake;
        logic ref_on;
        logic [2:0] conv_s;
        logic [2:0] lp_s;
        logic [2:0] cal_s;
        logic [2:0] mclk_s;
    } aps_regs_t;

endpackage

// file: core/aps_seq.sv
// power-state and calibration sequencer of a serial sar converter
// assumes pins arrive asynchronously and control writes come from logic on ref_clk_i
//
// Notes on behaviour
// - first convert pulse starts 35 ms cal
// - low-power pin ignored during power-on cal
// - early control write cancels power-on cal
// - wake from power-down takes 5 us
// - between-mode sleeps when busy falls at a conversion end
// - convert falling wakes except in full power-down, rising converts
// - software power-up command wakes device
// - policy bits and pin select power mode
// - cal starts on pin pulse or bit
// - cal durations per type, in clocks
// - cal pin rise before any convert pulse or write runs auto cal
// - conversion lasts 20 clocks, 3.25 us rounded up at 6 mhz
// - busy high through whole calibration
`timescale 1ns/1ps
`include "aps_consts.svh"

module aps_seq #(
    parameter int POR_CYC = `APS_POR_CYC,
    parameter int CAL_FULL_CYC = `APS_CAL_FULL_CYC,
    parameter int CAL_GO_CYC = `APS_CAL_GO_CYC,
    parameter int CAL_ONE_CYC = `APS_CAL_ONE_CYC,
    parameter int AUTO_CAL_CYC = `APS_AUTO_CAL_CYC,
    parameter int CONV_CYC = `APS_CONV_CYC,
    parameter int WAKE_CYC = `APS_WAKE_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic master_clock_in_i,
    input wire logic convert_start_n_i,
    input wire logic low_power_n_i,
    input wire logic cal_req_n_i,
    input wire logic ctrl_wr_i,
    input wire aps_pkg::aps_ctrl_t ctrl_data_i,
    input wire logic sw_convert_i,
    output logic busy_o,
    output logic awake_o,
    output logic ref_on_o,
    output aps_pkg::aps_state_t state_o
);

    localparam int CW = `APS_CNT_W;

    // refuse counts the counter cannot hold or that would never end
    generate
        if (POR_CYC < 1 || CAL_FULL_CYC < 1 || CAL_GO_CYC < 1 || CAL_ONE_CYC < 1
            || AUTO_CAL_CYC < 1 || CONV_CYC < 1 || WAKE_CYC < 1)
        begin : g_bad_min
            $error("aps_seq: every duration must be at least one cycle");
        end
        if (POR_CYC >= (1 << CW) || CAL_FULL_CYC >= (1 << CW) || CAL_GO_CYC >= (1 << CW)
            || CAL_ONE_CYC >= (1 << CW) || AUTO_CAL_CYC >= (1 << CW)
            || CONV_CYC >= (1 << CW) || WAKE_CYC >= (1 << CW))
        begin : g_bad_max
            $error("aps_seq: a duration does not fit the counter");
        end
    endgenerate

    // combine policy bits with the low-power pin
    function automatic aps_pkg::aps_policy_t policy_of(input aps_pkg::aps_ctrl_t c,
                                                       input logic lp_n);
        if (!c.power_policy_bit_hi && !c.power_policy_bit_lo)
        begin
            policy_of = lp_n ? aps_pkg::POL_POWER_UP : aps_pkg::POL_PD_BETWEEN_FULL;
        end
        else if (!c.power_policy_bit_hi)
        begin
            policy_of = aps_pkg::POL_PD_BETWEEN_FULL;
        end
        else if (!c.power_policy_bit_lo)
        begin
            policy_of = aps_pkg::POL_PD_FULL;
        end
        else
        begin
            policy_of = aps_pkg::POL_PD_BETWEEN_PART;
        end
    endfunction

    // calibration length for a type code, in master clock cycles
    function automatic logic [CW-1:0] cal_len(input logic [1:0] t);
        if (t == `APS_CAL_FULL)
        begin
            cal_len = CW'(CAL_FULL_CYC);
        end
        else if (t == `APS_CAL_GO)
        begin
            cal_len = CW'(CAL_GO_CYC);
        end
        else
        begin
            cal_len = CW'(CAL_ONE_CYC);
        end
    endfunction

    // reset release synchroniser; assertion stays asynchronous
    logic [1:0] rst_sync_q;
    logic rst_n;

    // two flops so the release is clean in this domain
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_sync_q <= 2'h0;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    aps_pkg::aps_regs_t s_q; // registered state
    aps_pkg::aps_regs_t s_d; // next state

    // decoded events; pin events from second and third sync stages, ctrl_cal straight from the write
    logic conv_fall;
    logic conv_rise;
    logic cal_fall;
    logic cal_rise;
    logic mclk_tick; // one-cycle enable per master clock rising edge
    aps_pkg::aps_policy_t pol; // effective policy now
    logic between; // either power-down-between option
    logic ctrl_cal; // write asks for a calibration

    assign conv_fall = s_q.conv_s[2] && !s_q.conv_s[1];
    assign conv_rise = !s_q.conv_s[2] && s_q.conv_s[1];
    assign cal_fall = s_q.cal_s[2] && !s_q.cal_s[1];
    assign cal_rise = !s_q.cal_s[2] && s_q.cal_s[1];
    assign mclk_tick = !s_q.mclk_s[2] && s_q.mclk_s[1];
    assign pol = policy_of(s_q.ctrl, s_q.lp_s[2]);
    assign between = (pol == aps_pkg::POL_PD_BETWEEN_FULL)
                     || (pol == aps_pkg::POL_PD_BETWEEN_PART);
    assign ctrl_cal = ctrl_wr_i && ctrl_data_i.trim_start_bit;

    // next-state logic of the whole sequencer
    always_comb
    begin
        s_d = s_q;
        // pin synchronisers, the first stage feeds only the second
        s_d.conv_s = {s_q.conv_s[1:0], convert_start_n_i};
        s_d.lp_s = {s_q.lp_s[1:0], low_power_n_i};
        s_d.cal_s = {s_q.cal_s[1:0], cal_req_n_i};
        s_d.mclk_s = {s_q.mclk_s[1:0], master_clock_in_i};
        // the start bit is a command, so it is not kept after the write
        if (ctrl_wr_i)
        begin
            s_d.ctrl = ctrl_data_i;
            s_d.ctrl.trim_start_bit = 1'b0;
        end
        case (s_q.st)
            // after supply-up: waiting for the first convert pulse or a write
            aps_pkg::ST_POR_WAIT:
            begin
                if (ctrl_wr_i)
                begin
                    // an early write cancels the power-on calibration
                    s_d.first_cal = 1'b0;
                    if (ctrl_cal)
                    begin
                        s_d.st = aps_pkg::ST_CAL;
                        s_d.cnt = cal_len(ctrl_data_i.cal_type);
                        s_d.busy = 1'b1;
                    end
                    else
                    begin
                        s_d.st = aps_pkg::ST_IDLE;
                    end
                end
                else if (conv_fall)
                begin
                    s_d.st = aps_pkg::ST_POR_CAL;
                    s_d.cnt = CW'(POR_CYC);
                    s_d.busy = 1'b1;
                end
                // cal pin released after supply-up runs the automatic full calibration
                else if (cal_rise)
                begin
                    s_d.st = aps_pkg::ST_CAL;
                    s_d.cnt = CW'(AUTO_CAL_CYC);
                    s_d.first_cal = 1'b0;
                    s_d.busy = 1'b1;
                end
            end
            // timeout plus self-calibration; low-power pin has no say here
            aps_pkg::ST_POR_CAL:
            begin
                if (mclk_tick)
                begin
                    if (s_q.cnt == CW'(1))
                    begin
                        s_d.st = aps_pkg::ST_IDLE;
                        s_d.busy = 1'b0;
                        s_d.first_cal = 1'b0;
                    end
                    else
                    begin
                        s_d.cnt = s_q.cnt - CW'(1);
                    end
                end
            end
            // powered, no activity
            aps_pkg::ST_IDLE:
            begin
                if (ctrl_cal)
                begin
                    s_d.st = aps_pkg::ST_CAL;
                    s_d.cnt = cal_len(ctrl_data_i.cal_type);
                    s_d.busy = 1'b1;
                end
                else if (cal_rise)
                begin
                    s_d.st = aps_pkg::ST_CAL;
                    // first_cal is always clear in this state, so a pin calibration takes the stored type's length
                    s_d.cnt = s_q.first_cal ? CW'(AUTO_CAL_CYC) : cal_len(s_q.ctrl.cal_type);
                    s_d.first_cal = 1'b0;
                    s_d.busy = 1'b1;
                end
                else if (conv_rise || sw_convert_i)
                begin
                    s_d.st = aps_pkg::ST_CONV;
                    s_d.cnt = CW'(CONV_CYC);
                    s_d.busy = 1'b1;
                end
                else if (pol == aps_pkg::POL_PD_FULL)
                begin
                    s_d.st = aps_pkg::ST_SLEEP;
                    s_d.awake = 1'b0;
                    s_d.ref_on = 1'b0;
                end
            end
            // powered down; the reference stays up only in the partial option
            aps_pkg::ST_SLEEP:
            begin
                if (ctrl_cal)
                begin
                    s_d.pend_cal = 1'b1;
                end
                // software wake needs a policy other than full power-down, or a cal start bit
                if ((ctrl_wr_i && (policy_of(ctrl_data_i, s_q.lp_s[2]) != aps_pkg::POL_PD_FULL))
                    || ctrl_cal)
                begin
                    s_d.st = aps_pkg::ST_WAKE;
                    s_d.cnt = CW'(WAKE_CYC);
                end
                else if ((conv_fall || cal_fall) && pol != aps_pkg::POL_PD_FULL)
                begin
                    s_d.st = aps_pkg::ST_WAKE;
                    s_d.cnt = CW'(WAKE_CYC);
                end
            end
            // settling after power-down, timed on the system clock
            aps_pkg::ST_WAKE:
            begin
                // a short convert pulse is held over rather than lost
                if (conv_rise || sw_convert_i)
                begin
                    s_d.pend_conv = 1'b1;
                end
                if (cal_rise || ctrl_cal)
                begin
                    s_d.pend_cal = 1'b1;
                end
                if (s_q.cnt == CW'(1))
                begin
                    s_d.awake = 1'b1;
                    s_d.ref_on = 1'b1;
                    s_d.pend_conv = 1'b0;
                    s_d.pend_cal = 1'b0;
                    if (s_q.pend_cal || cal_rise || ctrl_cal)
                    begin
                        s_d.st = aps_pkg::ST_CAL;
                        s_d.cnt = cal_len(ctrl_cal ? ctrl_data_i.cal_type : s_q.ctrl.cal_type);
                        s_d.busy = 1'b1;
                    end
                    else if (s_q.pend_conv || conv_rise || sw_convert_i)
                    begin
                        s_d.st = aps_pkg::ST_CONV;
                        s_d.cnt = CW'(CONV_CYC);
                        s_d.busy = 1'b1;
                    end
                    else
                    begin
                        s_d.st = aps_pkg::ST_IDLE;
                    end
                end
                else
                begin
                    s_d.cnt = s_q.cnt - CW'(1);
                end
            end
            // conversion; busy falls when the count runs out
            aps_pkg::ST_CONV:
            begin
                if (mclk_tick)
                begin
                    if (s_q.cnt == CW'(1))
                    begin
                        s_d.busy = 1'b0;
                        if (between || pol == aps_pkg::POL_PD_FULL)
                        begin
                            s_d.st = aps_pkg::ST_SLEEP;
                            s_d.awake = 1'b0;
                            s_d.ref_on = (pol == aps_pkg::POL_PD_BETWEEN_PART);
                        end
                        else
                        begin
                            s_d.st = aps_pkg::ST_IDLE;
                        end
                    end
                    else
                    begin
                        s_d.cnt = s_q.cnt - CW'(1);
                    end
                end
            end
            // calibration; busy stays high throughout
            aps_pkg::ST_CAL:
            begin
                if (mclk_tick)
                begin
                    if (s_q.cnt == CW'(1))
                    begin
                        s_d.busy = 1'b0;
                        s_d.st = aps_pkg::ST_IDLE;
                    end
                    else
                    begin
                        s_d.cnt = s_q.cnt - CW'(1);
                    end
                end
            end
            default:
            begin
                s_d.st = aps_pkg::ST_IDLE;
            end
        endcase
    end

    // state register; pins idle high so their synchronisers reset to one, the master clock one to zero
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '{st: aps_pkg::ST_POR_WAIT, cnt: '0, ctrl: '0, first_cal: 1'b1,
                     pend_conv: 1'b0, pend_cal: 1'b0, busy: 1'b0, awake: 1'b1,
                     ref_on: 1'b1, conv_s: 3'h7, lp_s: 3'h7, cal_s: 3'h7, mclk_s: 3'h0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops
    assign busy_o = s_q.busy;
    assign awake_o = s_q.awake;
    assign ref_on_o = s_q.ref_on;
    assign state_o = s_q.st;

endmodule

// file: testbench/aps_seq_monitor.sv
// port-level checker for the power and calibration sequencer
// assumes it is bound onto aps_seq and the low-power pin is steady near conversion ends
`timescale 1ns/1ps
`include "aps_consts.svh"
module aps_seq_monitor #(
    parameter int WAKE_CYC = `APS_WAKE_CYC // must match the bound sequencer's wake count
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic master_clock_in_i,
    input wire logic convert_start_n_i,
    input wire logic low_power_n_i,
    input wire logic cal_req_n_i,
    input wire logic ctrl_wr_i,
    input wire aps_pkg::aps_ctrl_t ctrl_data_i,
    input wire logic sw_convert_i,
    input wire logic busy_o,
    input wire logic awake_o,
    input wire logic ref_on_o,
    input wire aps_pkg::aps_state_t state_o
);
    logic [1:0] pol_q; // shadow of the stored policy bits
    logic between; // a conversion end must power down
    // the word is stored on every write, even when a cal start is refused
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pol_q <= 2'h0;
        else if (ctrl_wr_i)
            pol_q <= {ctrl_data_i.power_policy_bit_hi, ctrl_data_i.power_policy_bit_lo};
    end
    // pin only counts with both bits clear; raw pin is fine as it moves rarely
    assign between = (pol_q == 2'h0 && !low_power_n_i) || pol_q == 2'h1 || pol_q == 2'h3;
    logic [15:0] wake_n; // cycles spent settling so far
    // counted, not repeated: the settling window is hundreds of cycles long
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            wake_n <= 16'h0;
        else if (state_o == aps_pkg::ST_WAKE)
            wake_n <= wake_n + 16'h1;
        else
            wake_n <= 16'h0;
    end
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // wake: still down for four cycles, then up as the settling count reaches WAKE_CYC
    sequence s_asleep;
        !awake_o [*4];
    endsequence
    sequence s_woken;
        awake_o && wake_n == WAKE_CYC;
    endsequence
    por_hold_a: assert property (state_o == aps_pkg::ST_POR_CAL |-> busy_o && awake_o)
        else $error("power-on cal not busy or powered down");
    por_cancel_a: assert property (state_o == aps_pkg::ST_POR_WAIT && ctrl_wr_i
        && !ctrl_data_i.trim_start_bit |=> state_o inside {aps_pkg::ST_IDLE, aps_pkg::ST_SLEEP})
        else $error("early write did not cancel power-on cal");
    wake_time_a: assert property ($rose(state_o == aps_pkg::ST_WAKE)
        |-> s_asleep)
        else $error("wake-up time wrong");
    wake_end_a: assert property ($fell(state_o == aps_pkg::ST_WAKE) |-> s_woken)
        else $error("wake-up did not end on time");
    auto_sleep_a: assert property ($fell(busy_o) && $past(state_o) == aps_pkg::ST_CONV
        && between |-> state_o == aps_pkg::ST_SLEEP && !awake_o && ref_on_o == (pol_q == 2'h3))
        else $error("no power-down at end of conversion");
    sw_start_a: assert property (state_o == aps_pkg::ST_IDLE && sw_convert_i
        |=> state_o == aps_pkg::ST_CONV && busy_o)
        else $error("software convert not started");
    cal_write_a: assert property (state_o == aps_pkg::ST_IDLE && ctrl_wr_i
        && ctrl_data_i.trim_start_bit |=> busy_o && state_o == aps_pkg::ST_CAL)
        else $error("cal start bit did not start cal");
    cal_pin_a: assert property (state_o inside {aps_pkg::ST_IDLE, aps_pkg::ST_POR_WAIT}
        && $rose(cal_req_n_i)
        |-> ##[3:5] busy_o)
        else $error("busy late after cal pin rise");
    conv_busy_a: assert property ($rose(state_o == aps_pkg::ST_CONV)
        |-> (busy_o && state_o == aps_pkg::ST_CONV) [*8])
        else $error("conversion ended too soon");
endmodule
bind aps_seq aps_seq_monitor mon_u (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .master_clock_in_i(master_clock_in_i),
    .convert_start_n_i(convert_start_n_i), .low_power_n_i(low_power_n_i),
    .cal_req_n_i(cal_req_n_i), .ctrl_wr_i(ctrl_wr_i), .ctrl_data_i(ctrl_data_i),
    .sw_convert_i(sw_convert_i), .busy_o(busy_o), .awake_o(awake_o), .ref_on_o(ref_on_o),
    .state_o(state_o));

// file: testbench/aps_host_model.sv
// host-side model: free master clock plus the convert, cal and low-power pins
// assumes its tasks are called at ref clock falling edges
`timescale 1ns/1ps
module aps_host_model (
    input wire logic ref_clk_i,
    output logic master_clock_in_o,
    output logic convert_start_n_o,
    output logic low_power_n_o,
    output logic cal_req_n_o
);
    // master clock sped up to 25 mhz so the shortened counts stay short
    initial
    begin
        master_clock_in_o = 1'b0;
        convert_start_n_o = 1'b1;
        low_power_n_o = 1'b1;
        cal_req_n_o = 1'b1;
        #3;
        forever #20 master_clock_in_o = ~master_clock_in_o;
    end
    // callers keep the width above the wake time in between mode
    task automatic conv_pulse(input int low_cyc);
        convert_start_n_o = 1'b0;
        repeat (low_cyc) @(negedge ref_clk_i);
        convert_start_n_o = 1'b1;
        @(negedge ref_clk_i);
    endtask
    // cal request; the rising edge is what starts it
    task automatic cal_pulse(input int low_cyc);
        cal_req_n_o = 1'b0;
        repeat (low_cyc) @(negedge ref_clk_i);
        cal_req_n_o = 1'b1;
        @(negedge ref_clk_i);
    endtask
    task automatic set_lp(input logic v);
        low_power_n_o = v;
        @(negedge ref_clk_i);
    endtask
endmodule

// file: testbench/aps_seq_tb_top.sv
// self-checking bench: pins through the host model, control writes from here
// assumes shortened counts and four ref cycles per master tick
`timescale 1ns/1ps
`include "aps_consts.svh"
module aps_seq_tb_top;
    localparam int TICK = 4; // ref cycles per master tick
    localparam int CONV_N = `APS_CONV_CYC;
    localparam int WAKE_N = `APS_WAKE_CYC;
    int cal_tab[4] = '{40, 20, 10, 10}; // full, gain+offset, offset, gain
    logic [1:0] pols[3] = '{2'h0, 2'h1, 2'h3}; // power-up (pin high), between-full and between-partial policies
    logic ref_clk, rst_n, ctrl_wr, sw_conv, mck, conv_n, lp_n, cal_n, busy, awake, ref_on;
    aps_pkg::aps_ctrl_t ctrl_d;
    aps_pkg::aps_state_t st;
    int error_cnt = 0;
    int num_checks = 0;
    aps_host_model host_u (.ref_clk_i(ref_clk), .master_clock_in_o(mck),
        .convert_start_n_o(conv_n), .low_power_n_o(lp_n), .cal_req_n_o(cal_n));
    // conversion and wake keep their real counts; only the long calibrations are shortened
    aps_seq #(.POR_CYC(50), .CAL_FULL_CYC(40), .CAL_GO_CYC(20), .CAL_ONE_CYC(10),
        .AUTO_CAL_CYC(30)) dut_u (
        .ref_clk_i(ref_clk), .rst_n_i(rst_n), .master_clock_in_i(mck),
        .convert_start_n_i(conv_n), .low_power_n_i(lp_n), .cal_req_n_i(cal_n),
        .ctrl_wr_i(ctrl_wr), .ctrl_data_i(ctrl_d), .sw_convert_i(sw_conv),
        .busy_o(busy), .awake_o(awake), .ref_on_o(ref_on), .state_o(st));
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // one comparison; an unknown never passes
    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1)
        begin
            error_cnt++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // reset three cycles, then let the internal release settle
    task automatic do_reset;
        rst_n = 1'b0;
        cyc(3);
        rst_n = 1'b1;
        cyc(6);
    endtask
    // strobe drops a cycle before any next write, never same time step
    task automatic wr(input logic [1:0] pol, input logic start, input logic [1:0] ty);
        ctrl_d = {pol, start, ty};
        ctrl_wr = 1'b1;
        cyc(1);
        ctrl_wr = 1'b0;
        cyc(1);
    endtask
    // waits for busy, then checks its length in ticks with sync slack
    task automatic meas(input int ticks, input string msg);
        int n;
        n = 0;
        for (int w = 0; w < 100 && busy !== 1'b1; w++)
            cyc(1);
        while (busy === 1'b1 && n < 2000)
        begin
            cyc(1);
            n++;
        end
        chk(n >= ticks * TICK - 4 && n <= ticks * TICK + 8, msg);
    endtask
    initial
    begin
        rst_n = 1'b0;
        ctrl_wr = 1'b0;
        sw_conv = 1'b0;
        ctrl_d = '0;
        do_reset;
        chk(busy === 1'b0 && awake === 1'b1 && ref_on === 1'b1, "reset outputs");
        chk(st === aps_pkg::ST_POR_WAIT, "reset state");
        $display("test reset done");
        // power-on cal with the low-power pin already low
        host_u.set_lp(1'b0);
        host_u.conv_pulse(2);
        meas(50, "power-on cal length");
        host_u.conv_pulse(WAKE_N + 8);
        meas(CONV_N, "first conversion length");
        chk(st === aps_pkg::ST_SLEEP && awake === 1'b0, "awake after conversion");
        fork
            host_u.conv_pulse(WAKE_N + 8);
            begin
                cyc(7);
                chk(st === aps_pkg::ST_WAKE && awake === 1'b0, "falling edge did not wake");
            end
        join
        meas(CONV_N, "conversion after wake");
        chk(st === aps_pkg::ST_SLEEP, "awake after second conversion");
        $display("test power-on and between mode done");
        host_u.set_lp(1'b1);
        wr(2'h0, 1'b0, 2'h0);
        cyc(WAKE_N + 6);
        chk(awake === 1'b1 && st === aps_pkg::ST_IDLE, "write did not wake");
        for (int i = 0; i < 3; i++)
        begin
            wr(pols[i], 1'b0, 2'h0);
            sw_conv = 1'b1;
            cyc(1);
            sw_conv = 1'b0;
            meas(CONV_N, "software conversion length");
            chk(awake === (pols[i] == 2'h0), "power after conversion");
            chk(ref_on === (pols[i] != 2'h1), "reference after conversion");
            wr(2'h0, 1'b0, 2'h0);
            cyc(WAKE_N + 6);
        end
        wr(2'h2, 1'b0, 2'h0);
        cyc(2);
        chk(st === aps_pkg::ST_SLEEP && awake === 1'b0 && ref_on === 1'b0, "full down");
        wr(2'h0, 1'b0, 2'h0);
        cyc(WAKE_N + 6);
        $display("test power policies done");
        for (int t = 0; t < 4; t++)
        begin
            wr(2'h0, 1'b1, t[1:0]);
            meas(cal_tab[t], "calibration length");
        end
        host_u.cal_pulse(3);
        meas(10, "pin calibration length");
        $display("test calibration done");
        do_reset;
        wr(2'h0, 1'b0, 2'h0);
        chk(st === aps_pkg::ST_IDLE, "power-on cal not cancelled");
        host_u.conv_pulse(2);
        meas(CONV_N, "conversion after cancel");
        cyc(100); // host lets supplies and reference settle first
        wr(2'h0, 1'b1, 2'h1);
        meas(20, "calibration after cancel");
        do_reset;
        host_u.cal_pulse(3);
        meas(30, "automatic calibration length");
        $display("test cancel and autocal done");
        finish_test;
    end
    // the run needs about 5000 cycles; far beyond that is a hang
    initial
    begin
        cyc(20000);
        error_cnt++;
        $display("mismatch at %0t: watchdog expired", $time);
        finish_test;
    end
endmodule
